// ===== src/tag_flag_params.svh
// Constants for the tag reader parallel handshake block
// Function
// - Plain read ignores host_data_in lines
// - Plain read drives tag byte out
// - Strobe 3 ms after data, held
// - Plain read data held until next result
// - Request without tag flags error, held
// - Error clears outputs, flashes error code
// - Hold_until_next_request setting holds until next request
// - Compare sets match or mismatch line
// - Indicators show new reference at access
// - Compare clears outputs at strobe
// - Suppress clears strobe and error at once
// - Suppress zeroes outputs and indicators
// - Write forms: full, bit set, bit clear
// - Presence write starts on tag arrival
// - Write start shows data, zeroes outputs
// - Write done raises strobe, held
// - Tag leaving mid-access flags error
`ifndef TAG_FLAG_PARAMS_SVH
`define TAG_FLAG_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ 20000000
`define TICK_MS 1
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000) * `TICK_MS)
`define STROBE_DELAY_MS 3
`define OUT_TIME_MS_DEFAULT 100
`define FLASH_HALF_MS 250

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define DATA_RESET 8'h00
`define ERR_CODE_NO_TAG 8'h01
`define ERR_CODE_TAG_LOST 8'h02

`endif

// ===== src/tag_flag_pkg.sv
// Types of the tag reader parallel handshake block
package tag_flag_pkg;

  typedef enum logic [1:0] {
    WR_FULL_WORD,
    WR_BIT_OR,
    WR_BIT_CLEAR
  } write_form_t;

  typedef enum {
    ST_IDLE,
    ST_ACCESS,
    ST_DELAY,
    ST_HOLD
  } flag_state_t;

endpackage

// ===== src/ms_tick_gen.sv
// Millisecond tick generator
`timescale 1ns/1ps
module ms_tick_gen #(
  parameter int CYCLES = 20000
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Tick
  output logic tick_out
);

  logic [31:0] count_reg;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_reg <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (count_reg == 32'(CYCLES - 1)) begin
      count_reg <= 32'h0000_0000;
      tick_out <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end

endmodule // ms_tick_gen

// ===== src/tag_reader_parallel_handshake.sv
// Device side of the tag reader parallel discrete handshake
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "tag_flag_params.svh"
module tag_reader_parallel_handshake #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int STROBE_DELAY_MS = `STROBE_DELAY_MS,
  parameter int FLASH_HALF_MS = `FLASH_HALF_MS
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Host discrete lines (pins)
  input wire logic rw_select_in,
  input wire logic carrier_access_request_in,
  input wire logic access_suppress_in,
  input wire logic [7:0] host_data_in,
  // Configuration straps
  input wire logic presence_triggered_in,
  input wire logic compare_read_in,
  input wire logic [1:0] write_form_in,
  input wire logic hold_until_next_request_in,
  input wire logic [15:0] out_time_ms_in,
  // Abstract tag access
  input wire logic tag_present_in,
  input wire logic tag_done_in,
  input wire logic tag_fail_in,
  input wire logic [7:0] tag_rdata_in,
  output logic tag_req_out,
  output logic tag_write_out,
  output logic [7:0] tag_wdata_out,
  // Host result lines
  output logic [7:0] tag_data_out,
  output logic completion_strobe_out,
  output logic error_out,
  // Indicators
  output logic [7:0] data_led_out,
  output logic error_led_out
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree.
  logic [2:0] rw_sync_reg, req_sync_reg, sup_sync_reg;
  logic [7:0] din_s1_reg, din_s2_reg, din_s3_reg;
  logic rw_q, req_q, sup_q, req_prev_reg;
  logic [7:0] din_q;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rw_sync_reg <= 3'h0;
      req_sync_reg <= 3'h0;
      sup_sync_reg <= 3'h0;
      din_s1_reg <= 8'h00;
      din_s2_reg <= 8'h00;
      din_s3_reg <= 8'h00;
    end else begin
      rw_sync_reg <= {rw_sync_reg[1:0], rw_select_in};
      req_sync_reg <= {req_sync_reg[1:0], carrier_access_request_in};
      sup_sync_reg <= {sup_sync_reg[1:0], access_suppress_in};
      din_s1_reg <= host_data_in;
      din_s2_reg <= din_s1_reg;
      din_s3_reg <= din_s2_reg;
    end
  end

  // Filtered levels: only move when stages two and three agree
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rw_q <= 1'b0;
      req_q <= 1'b0;
      sup_q <= 1'b0;
      din_q <= 8'h00;
    end else begin
      if (rw_sync_reg[1] == rw_sync_reg[2]) begin
        rw_q <= rw_sync_reg[2];
      end
      if (req_sync_reg[1] == req_sync_reg[2]) begin
        req_q <= req_sync_reg[2];
      end
      if (sup_sync_reg[1] == sup_sync_reg[2]) begin
        sup_q <= sup_sync_reg[2];
      end
      if (din_s2_reg == din_s3_reg) begin
        din_q <= din_s3_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_prev_reg <= 1'b0;
    end else begin
      req_prev_reg <= req_q;
    end
  end

  logic req_rise;
  assign req_rise = req_q && !req_prev_reg;

  // --------------------------------------------------------------------
  // Millisecond tick
  // --------------------------------------------------------------------
  logic tick;

  ms_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .tick_out(tick)
  );

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [7:0] apply_write(
    input logic [1:0] form,
    input logic [7:0] old_val,
    input logic [7:0] sel
  );
    unique case (form)
      tag_flag_pkg::WR_BIT_OR: apply_write = old_val | sel;
      tag_flag_pkg::WR_BIT_CLEAR: apply_write = old_val & ~sel;
      default: apply_write = sel;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------
  tag_flag_pkg::flag_state_t state_reg;
  logic [15:0] ms_cnt_reg;
  logic access_err_reg;
  logic is_write_reg;
  logic is_compare_reg;
  logic [7:0] ref_reg;
  logic [7:0] result_reg;
  logic [7:0] err_code_reg;
  logic tag_prev_reg;
  logic tag_arrive;
  logic start_ok;
  logic start_no_tag;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tag_prev_reg <= 1'b0;
    end else begin
      tag_prev_reg <= tag_present_in;
    end
  end

  assign tag_arrive = tag_present_in && !tag_prev_reg;
  // Presence write needs no trigger; every other access is host started
  assign start_ok = !sup_q && state_reg != tag_flag_pkg::ST_ACCESS &&
    ((presence_triggered_in && rw_q && tag_arrive) ||
     (!presence_triggered_in && req_rise && tag_present_in));
  assign start_no_tag = !sup_q && !presence_triggered_in && req_rise &&
    !tag_present_in && state_reg != tag_flag_pkg::ST_ACCESS;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= tag_flag_pkg::ST_IDLE;
      ms_cnt_reg <= 16'h0000;
      access_err_reg <= 1'b0;
      is_write_reg <= 1'b0;
      is_compare_reg <= 1'b0;
      ref_reg <= `DATA_RESET;
      result_reg <= `DATA_RESET;
      err_code_reg <= `DATA_RESET;
    end else if (sup_q) begin
      state_reg <= tag_flag_pkg::ST_IDLE;
      access_err_reg <= 1'b0;
    end else if (start_no_tag) begin
      state_reg <= tag_flag_pkg::ST_HOLD;
      ms_cnt_reg <= 16'h0000;
      access_err_reg <= 1'b1;
      err_code_reg <= `ERR_CODE_NO_TAG;
    end else if (start_ok) begin
      state_reg <= tag_flag_pkg::ST_ACCESS;
      access_err_reg <= 1'b0;
      is_write_reg <= rw_q;
      is_compare_reg <= !rw_q && compare_read_in;
      ref_reg <= din_q;
    end else begin
      unique case (state_reg)
        tag_flag_pkg::ST_IDLE: begin
          ms_cnt_reg <= 16'h0000;
        end
        tag_flag_pkg::ST_ACCESS: begin
          ms_cnt_reg <= 16'h0000;
          if (tag_fail_in || !tag_present_in) begin
            state_reg <= tag_flag_pkg::ST_HOLD;
            access_err_reg <= 1'b1;
            err_code_reg <= `ERR_CODE_TAG_LOST;
          end else if (tag_done_in) begin
            result_reg <= tag_rdata_in;
            // Writes report straight away; reads wait for data to settle
            state_reg <= is_write_reg ? tag_flag_pkg::ST_HOLD
                                      : tag_flag_pkg::ST_DELAY;
          end
        end
        tag_flag_pkg::ST_DELAY: begin
          if (tick) begin
            if (ms_cnt_reg == 16'(STROBE_DELAY_MS - 1)) begin
              state_reg <= tag_flag_pkg::ST_HOLD;
              ms_cnt_reg <= 16'h0000;
            end else begin
              ms_cnt_reg <= ms_cnt_reg + 16'h0001;
            end
          end
        end
        tag_flag_pkg::ST_HOLD: begin
          // Hold_until_next_request setting never times out; next request ends it
          if (tick && !hold_until_next_request_in) begin
            if (ms_cnt_reg + 16'h0001 >= out_time_ms_in) begin
              state_reg <= tag_flag_pkg::ST_IDLE;
              ms_cnt_reg <= 16'h0000;
            end else begin
              ms_cnt_reg <= ms_cnt_reg + 16'h0001;
            end
          end
        end
      endcase
    end
  end

  logic in_hold;
  assign in_hold = state_reg == tag_flag_pkg::ST_HOLD;

  // --------------------------------------------------------------------
  // Tag access port
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tag_req_out <= 1'b0;
      tag_write_out <= 1'b0;
      tag_wdata_out <= 8'h00;
    end else begin
      tag_req_out <= state_reg == tag_flag_pkg::ST_ACCESS && !sup_q &&
        !tag_done_in && !tag_fail_in;
      tag_write_out <= is_write_reg;
      // Captured once on completion so the word stands through the strobe
      if (state_reg == tag_flag_pkg::ST_ACCESS && tag_done_in) begin
        tag_wdata_out <= apply_write(write_form_in, tag_rdata_in,
          ref_reg);
      end
    end
  end

  // --------------------------------------------------------------------
  // Result lines
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tag_data_out <= `DATA_RESET;
    end else if (sup_q || access_err_reg) begin
      tag_data_out <= 8'h00;
    end else if (start_ok && rw_q) begin
      // Reads keep the previous result until new data arrives
      tag_data_out <= 8'h00;
    end else if (state_reg == tag_flag_pkg::ST_ACCESS && tag_done_in &&
                 !tag_fail_in && tag_present_in && !is_write_reg) begin
      if (is_compare_reg) begin
        // Middle six lines stay low in compare mode
        tag_data_out <= {tag_rdata_in != ref_reg, 6'h00,
          tag_rdata_in == ref_reg};
      end else begin
        tag_data_out <= tag_rdata_in;
      end
    end else if (is_compare_reg && in_hold && !access_err_reg &&
                 !completion_strobe_out) begin
      // Same edge that raises the strobe
      tag_data_out <= 8'h00;
    end
  end

  logic verify_match_out, verify_mismatch_out;
  assign verify_match_out = tag_data_out[0];
  assign verify_mismatch_out = tag_data_out[7];

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      completion_strobe_out <= 1'b0;
      error_out <= 1'b0;
    end else begin
      completion_strobe_out <= in_hold && !access_err_reg && !sup_q &&
        !start_ok && !start_no_tag;
      // High level means error; low means no error is being held
      error_out <= in_hold && access_err_reg && !sup_q &&
        !start_ok;
    end
  end

  // --------------------------------------------------------------------
  // Indicators
  // --------------------------------------------------------------------
  logic [15:0] flash_cnt_reg;
  logic flash_on_reg;
  logic err_showing_reg;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flash_cnt_reg <= 16'h0000;
      flash_on_reg <= 1'b0;
    end else if (tick) begin
      if (flash_cnt_reg == 16'(FLASH_HALF_MS - 1)) begin
        flash_cnt_reg <= 16'h0000;
        flash_on_reg <= !flash_on_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 16'h0001;
      end
    end
  end

  // Error display lasts until an access starts outside the error hold, not the hold time
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      err_showing_reg <= 1'b0;
    end else if (start_no_tag || (access_err_reg && in_hold)) begin
      err_showing_reg <= 1'b1;
    end else if (start_ok || sup_q) begin
      err_showing_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      data_led_out <= 8'h00;
      error_led_out <= 1'b0;
    end else begin
      error_led_out <= err_showing_reg && !sup_q;
      if (sup_q) begin
        data_led_out <= 8'h00;
      end else if (err_showing_reg) begin
        data_led_out <= flash_on_reg ? err_code_reg : 8'h00;
      end else if (state_reg == tag_flag_pkg::ST_ACCESS &&
                   (is_write_reg || is_compare_reg)) begin
        data_led_out <= ref_reg;
      end else if (state_reg != tag_flag_pkg::ST_ACCESS &&
                   !is_write_reg && !is_compare_reg) begin
        data_led_out <= tag_data_out;
      end else if (is_compare_reg && !in_hold &&
                   state_reg != tag_flag_pkg::ST_ACCESS) begin
        data_led_out <= ref_reg;
      end
    end
  end

endmodule // tag_reader_parallel_handshake

// ===== sim/tag_model.sv
// Behavioural tag seen through the abstract access port
`timescale 1ns/1ps
module tag_model (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Scene set by the bench
  input wire logic in_area_in,
  input wire logic [7:0] byte_in,
  input wire logic [7:0] wait_in,
  // Device side
  input wire logic tag_req_in,
  output logic tag_present_out,
  output logic tag_done_out,
  output logic tag_fail_out,
  output logic [7:0] tag_rdata_out
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  assign tag_present_out = in_area_in;
  assign tag_fail_out = 1'b0;
  // A departed tag never answers; data is inverted off the done cycle
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_reg <= 8'h00;
      busy_reg <= 1'b0;
      tag_done_out <= 1'b0;
      tag_rdata_out <= 8'h00;
    end else begin
      tag_done_out <= 1'b0;
      tag_rdata_out <= ~byte_in;
      if (!in_area_in) begin
        busy_reg <= 1'b0;
      end else if (busy_reg && cnt_reg == wait_in) begin
        busy_reg <= 1'b0;
        tag_done_out <= 1'b1;
        tag_rdata_out <= byte_in;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 8'h01;
      end else if (tag_req_in && !tag_done_out) begin
        busy_reg <= 1'b1;
        cnt_reg <= 8'h00;
      end
    end
  end
endmodule // tag_model

// ===== sim/tag_handshake_chk.sv
// Port assertions for the tag reader handshake
`timescale 1ns/1ps
module tag_handshake_chk (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Watched ports
  input wire logic rw_select_in,
  input wire logic carrier_access_request_in,
  input wire logic access_suppress_in,
  input wire logic compare_read_in,
  input wire logic presence_triggered_in,
  input wire logic hold_until_next_request_in,
  input wire logic tag_present_in,
  input wire logic tag_done_in,
  input wire logic tag_req_out,
  input wire logic tag_write_out,
  input wire logic [7:0] tag_data_out,
  input wire logic completion_strobe_out,
  input wire logic error_out,
  input wire logic [7:0] data_led_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_no_tag_err: assert property (
    $rose(carrier_access_request_in) && !tag_present_in && !tag_req_out
    && !access_suppress_in |-> ##[3:7] error_out)
    else $error("no-tag request raised no error");
  a_suppress_clr: assert property (
    access_suppress_in [*6] |-> !completion_strobe_out && !error_out
    && tag_data_out == 8'h00 && data_led_out == 8'h00)
    else $error("suppress left outputs set");
  a_compare_bits: assert property (
    compare_read_in && !rw_select_in && tag_data_out != 8'h00
    |-> tag_data_out == 8'h01 || tag_data_out == 8'h80)
    else $error("compare result lines malformed");
  a_read_delay: assert property (
    tag_done_in && !tag_write_out && !access_suppress_in
    |-> !completion_strobe_out [*8] ##[12:28] completion_strobe_out)
    else $error("read strobe delay wrong");
  a_cont_hold: assert property (
    hold_until_next_request_in && completion_strobe_out
    && !access_suppress_in && !carrier_access_request_in
    |=> completion_strobe_out)
    else $error("hold_until_next_request strobe dropped");
  a_write_done: assert property (
    tag_done_in && tag_write_out && !access_suppress_in
    |-> ##2 completion_strobe_out)
    else $error("write strobe missing");
  a_presence_go: assert property (
    presence_triggered_in && rw_select_in && $rose(tag_present_in)
    && !access_suppress_in |-> ##[1:6] (tag_req_out && tag_write_out
    && tag_data_out == 8'h00))
    else $error("presence write did not start");
  a_tag_lost: assert property (
    tag_req_out && $fell(tag_present_in) |-> ##[1:5] error_out)
    else $error("tag loss raised no error");
endmodule // tag_handshake_chk
bind tag_reader_parallel_handshake tag_handshake_chk chk (
  .ref_clk_in, .sys_rst_in, .rw_select_in, .carrier_access_request_in,
  .access_suppress_in, .compare_read_in, .presence_triggered_in,
  .hold_until_next_request_in, .tag_present_in, .tag_done_in,
  .tag_req_out, .tag_write_out, .tag_data_out, .completion_strobe_out,
  .error_out, .data_led_out);

// ===== sim/tb.sv
// Self-checking bench for the tag reader handshake
`timescale 1ns/1ps
module tb;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic rw = 1'b0, req = 1'b0, sup = 1'b0, pres = 1'b0;
  logic cmp = 1'b0, hold = 1'b0, area = 1'b0;
  logic [1:0] form = 2'h0;
  logic [7:0] hdata = 8'h00, tbyte = 8'h00, twait = 8'h14;
  logic present, done, fail, treq, twr, strobe, err, eled;
  logic [7:0] rdata, wdata, dout, led;
  logic [3:0] mon;
  logic [7:0] exp_w [3] = '{8'h0F, 8'h3F, 8'h30};
  int miscompares = 0, checks_done = 0, cyc = 0;
  assign mon = {!treq, treq, err, strobe};

  initial begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  tag_reader_parallel_handshake #(.TICK_CYCLES(10)) uut (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .rw_select_in(rw), .carrier_access_request_in(req),
    .access_suppress_in(sup), .host_data_in(hdata),
    .presence_triggered_in(pres), .compare_read_in(cmp),
    .write_form_in(form), .hold_until_next_request_in(hold),
    .out_time_ms_in(16'h0004), .tag_present_in(present),
    .tag_done_in(done), .tag_fail_in(fail), .tag_rdata_in(rdata),
    .tag_req_out(treq), .tag_write_out(twr), .tag_wdata_out(wdata),
    .tag_data_out(dout), .completion_strobe_out(strobe),
    .error_out(err), .data_led_out(led), .error_led_out(eled));

  tag_model tag (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .in_area_in(area), .byte_in(tbyte), .wait_in(twait),
    .tag_req_in(treq), .tag_present_out(present),
    .tag_done_out(done), .tag_fail_out(fail), .tag_rdata_out(rdata));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  // Polls at falling edges so registered outputs have settled
  task automatic wait_for(input int which);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    while (mon[which] !== 1'b1 && n < 400) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("wait", {7'h00, mon[which]}, 8'h01);
  endtask

  // Request held 10 ms in the background
  task automatic trig;
    tk(1);
    fork
      begin
        req <= 1'b1;
        tk(100);
        req <= 1'b0;
      end
    join_none
  endtask

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    tk(4);
    sys_rst_in <= 1'b0;
    area <= 1'b1;
    tbyte <= 8'hC3;
    for (int i = 0; i < 2; i++) begin
      hdata <= i ? 8'hFF : 8'h5A;
      tk(100);
      trig();
      wait_for(0);
      chk("plain data", dout, 8'hC3);
      chk("plain led", led, 8'hC3);
      tk(60);
      chk("strobe end", {7'h00, strobe}, 8'h00);
      chk("data held", dout, 8'hC3);
    end
    area <= 1'b0;
    trig();
    wait_for(1);
    chk("err data", dout, 8'h00);
    chk("err led", {7'h00, eled}, 8'h01);
    tk(160);
    chk("err end", {7'h00, err}, 8'h00);
    cmp <= 1'b1;
    area <= 1'b1;
    tbyte <= 8'hAA;
    for (int i = 0; i < 2; i++) begin
      hdata <= i ? 8'h55 : 8'hAA;
      tk(100);
      trig();
      wait_for(2);
      chk("ref led", led, i ? 8'h55 : 8'hAA);
      wait_for(3);
      chk("verify", dout, i ? 8'h80 : 8'h01);
      wait_for(0);
      chk("verify clr", dout, 8'h00);
      tk(100);
    end
    cmp <= 1'b0;
    hold <= 1'b1;
    tbyte <= 8'h96;
    trig();
    wait_for(0);
    tk(150);
    chk("cont strobe", {7'h00, strobe}, 8'h01);
    sup <= 1'b1;
    tk(10);
    chk("sup strobe", {7'h00, strobe}, 8'h00);
    chk("sup data", dout, 8'h00);
    chk("sup led", led, 8'h00);
    tk(190);
    sup <= 1'b0;
    hold <= 1'b0;
    area <= 1'b0;
    pres <= 1'b1;
    rw <= 1'b1;
    hdata <= 8'h0F;
    tbyte <= 8'h3C;
    tk(100);
    for (int f = 0; f < 3; f++) begin
      form <= f[1:0];
      tk(10);
      area <= 1'b1;
      wait_for(2);
      chk("wr out", dout, 8'h00);
      chk("wr led", led, 8'h0F);
      wait_for(0);
      chk("wr form", wdata, exp_w[f]);
      tk(60);
      area <= 1'b0;
      tk(20);
    end
    twait <= 8'h64;
    tk(1);
    area <= 1'b1;
    wait_for(2);
    tk(5);
    area <= 1'b0;
    wait_for(1);
    chk("lost data", dout, 8'h00);
    give_verdict();
  end
endmodule // tb
